// *** hw/kd_regs.svh ***
// Purpose: Constants for the key and input command decoder
// Assumes: 20 MHz system clock
// Notes: Times are kept in their own units; cycle counts derive from them
`ifndef KD_REGS_SVH
`define KD_REGS_SVH

// ****************************************
// Timing
// ****************************************
`define KD_CLK_HZ 20000000
`define KD_MIN_PULSE_MS 200
`define KD_FAST_HOLD_US 100
`define KD_COMBINE_MS 20
`define KD_MIN_PULSE_CYC ((`KD_CLK_HZ / 1000) * `KD_MIN_PULSE_MS)
`define KD_FAST_HOLD_CYC ((`KD_CLK_HZ / 1000000) * `KD_FAST_HOLD_US)
`define KD_COMBINE_CYC ((`KD_CLK_HZ / 1000) * `KD_COMBINE_MS)

// ****************************************
// Chord bit positions, chord codes and counter width
// ****************************************
`define KD_BIT_MODE 3
`define KD_BIT_ZERO 2
`define KD_BIT_LIMITS 1
`define KD_BIT_RESET 0
`define KD_CH_ZERO 4'h4
`define KD_CH_ZERO_RESET 4'h5
`define KD_CH_MODE 4'h8
`define KD_CH_MODE_RESET 4'h9
`define KD_CH_MODE_ZERO 4'hc
`define KD_CH_MODE_LIMITS 4'ha
`define KD_CH_LIMITS_RESET 4'h3
`define KD_CH_RESET 4'h1
`define KD_CNT_W 22

`endif

// *** hw/kd_pkg.sv ***
// Purpose: Types shared by the decoder modules
// Assumes: Nothing beyond the constants header
// Notes: Codes are written out so waveforms read plainly
`default_nettype none
package kd_pkg;
  typedef enum logic [1:0] {
    VIEW_NORMAL = 2'h0,
    VIEW_MAX = 2'h1,
    VIEW_MIN = 2'h2,
    VIEW_TOTAL_INDICATED_READING = 2'h3
  } view_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SETTLE = 2'h1,
    ST_DONE = 2'h2
  } state_t;
endpackage : kd_pkg
`default_nettype wire

// *** hw/qual_if.sv ***
// Purpose: Carries one raw command line pair into a qualifier
// Assumes: key is active high, ext_n is active low
// Notes: active is the filtered, qualified level
`default_nettype none
interface qual_if;
  logic key;
  logic ext_n;
  logic active;
  modport src (output key, output ext_n, input active);
  modport sink (input key, input ext_n, output active);
endinterface : qual_if
`default_nettype wire

// *** hw/input_qualifier.sv ***
// Purpose: Synchronise a key and an external line, then qualify width
// Assumes: Both lines are asynchronous to i_clk_sys
// Notes: Release is immediate; only assertion must meet the width
`default_nettype none
module input_qualifier #(
  parameter int CNT_W = 22,
  parameter int LIMIT = 4000000
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  qual_if.sink q
);
  logic key_s1_q, key_s2_q, ext_s1_q, ext_s2_q;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic level_q, level_d;
  logic raw;

  // Two stages on each pin before anything looks at it
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      key_s1_q <= 1'b0;
      key_s2_q <= 1'b0;
      ext_s1_q <= 1'b1;
      ext_s2_q <= 1'b1;
    end else begin
      key_s1_q <= q.key;
      key_s2_q <= key_s1_q;
      ext_s1_q <= q.ext_n;
      ext_s2_q <= ext_s1_q;
    end
  end

  // External line acts exactly as its key; low means asserted
  assign raw = key_s2_q | ~ext_s2_q; // RULE1 RULE2 RULE3 RULE4

  // Any dropout restarts the count, so bounce never qualifies
  always_comb begin
    cnt_d = cnt_q;
    level_d = level_q;
    if (!raw) begin
      cnt_d = '0; // RULE20
      level_d = 1'b0; // RULE12 RULE13
    end else if (cnt_q == CNT_W'(LIMIT - 1)) begin
      level_d = 1'b1; // RULE11 RULE13
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= '0;
      level_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      level_q <= level_d;
    end
  end

  assign q.active = level_q;

  short_pulse_a: assert property (@(posedge i_clk_sys) // RULE20
    disable iff (!i_resetn)
    $rose(level_q) |-> $past(cnt_q) == CNT_W'(LIMIT - 1) && $past(raw))
    else $error("qualified level rose before full width");
  level_release_a: assert property (@(posedge i_clk_sys) // RULE12
    disable iff (!i_resetn) !raw |=> !level_q)
    else $error("qualified level outlived its input");
endmodule : input_qualifier
`default_nettype wire

// *** hw/key_and_input_command_decoder.sv ***
// Purpose: Decode four keys and rear inputs into operating commands
// Assumes: Keys active high, rear inputs active low, 20 MHz clock
// Notes: Chords settle for a short window before one command fires
// Function
// [RULE1] Rear mode input acts as mode key
// [RULE2] Zero input alone takes new zero
// [RULE3] Rear limits input acts as limits key
// [RULE4] Reset alone holds display; combines as reset
// [RULE5] Zero with reset restores calibration zero
// [RULE6] Mode alone steps max, min, total, normal
// [RULE7] Mode with reset clears max, min, total
// [RULE8] Mode with zero steps function if several
// [RULE9] Mode with limits starts amplifier check
// [RULE10] Limits with reset clears latched limits
// [RULE11] Commands need 200ms, act within 200ms
// [RULE12] Digital hold 200ms in, released on removal
// [RULE13] Fast hold 0.1ms in, released on removal
// [RULE14] Fast hold freezes display and analogue output
// [RULE15] Driver should add digital hold after fast
// [RULE16] Non-isolated inputs assert on logic low
// [RULE17] Isolated inputs assert by applied voltage
// [RULE18] Indicators show max, min or both
// [RULE19] Chords are one command, once per press
// [RULE20] Short pulses are filtered as noise
`include "kd_regs.svh"
`default_nettype none
module key_and_input_command_decoder #(
  parameter int MIN_PULSE_CYC = `KD_MIN_PULSE_CYC,
  parameter int COMBINE_CYC = `KD_COMBINE_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_key_mode,
  input wire logic i_key_zero,
  input wire logic i_key_limits,
  input wire logic i_key_reset,
  input wire logic i_ext_mode_n,
  input wire logic i_ext_zero_n,
  input wire logic i_ext_limits_n,
  input wire logic i_ext_reset_n,
  input wire logic i_ext_fast_hold_n,
  input wire logic i_multi_function,
  output logic o_zero_capture,
  output logic o_zero_clear,
  output logic o_peaks_clear,
  output logic o_function_next,
  output logic o_amp_check,
  output logic o_limits_clear,
  output logic o_digital_hold,
  output logic o_freeze_display,
  output logic o_freeze_analogue,
  output logic [1:0] o_view,
  output logic o_ind_up,
  output logic o_ind_down
);
  localparam int FAST_CYC = `KD_FAST_HOLD_CYC;
  localparam int CW = `KD_CNT_W;

  // ****************************************
  // Input qualification
  // ****************************************
  logic [4:0] key_in, ext_in_n, qual;
  logic [3:0] chord;
  assign key_in = {1'b0, i_key_mode, i_key_zero, i_key_limits, i_key_reset};
  assign ext_in_n = {i_ext_fast_hold_n, i_ext_mode_n, i_ext_zero_n,
                     i_ext_limits_n, i_ext_reset_n}; // RULE16 RULE17

  // Fast hold has no key and a much shorter width
  for (genvar g = 0; g < 5; g++) begin : g_qual
    qual_if q ();
    assign q.key = key_in[g];
    assign q.ext_n = ext_in_n[g];
    assign qual[g] = q.active;
    input_qualifier #(
      .CNT_W(CW),
      .LIMIT((g == 4) ? FAST_CYC : MIN_PULSE_CYC)
    ) u_qual (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .q(q)
    );
  end
  assign chord = qual[3:0];

  // Strap-like config level still crosses into the clock domain
  logic multi_s1_q, multi_s2_q;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      multi_s1_q <= 1'b0;
      multi_s2_q <= 1'b0;
    end else begin
      multi_s1_q <= i_multi_function;
      multi_s2_q <= multi_s1_q;
    end
  end

  // ****************************************
  // Chord sequencer
  // ****************************************
  kd_pkg::state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [3:0] last_q, last_d;
  logic fire;

  // A chord must stand unchanged for the window; keys need not land together
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    last_d = chord;
    fire = 1'b0;
    unique case (state_q)
      kd_pkg::ST_IDLE: begin
        cnt_d = '0;
        if (chord != 4'h0) begin
          state_d = kd_pkg::ST_SETTLE;
        end
      end
      kd_pkg::ST_SETTLE: begin
        if (chord == 4'h0) begin
          state_d = kd_pkg::ST_IDLE;
        end else if (chord != last_q) begin
          cnt_d = '0; // RULE19
        end else if (cnt_q == CW'(COMBINE_CYC - 1)) begin
          fire = 1'b1;
          state_d = kd_pkg::ST_DONE; // RULE19
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      kd_pkg::ST_DONE: begin
        cnt_d = '0;
        if (chord == 4'h0) begin
          state_d = kd_pkg::ST_IDLE; // RULE19
        end
      end
      default: begin
        state_d = kd_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= kd_pkg::ST_IDLE;
      cnt_q <= '0;
      last_q <= 4'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      last_q <= last_d;
    end
  end

  // ****************************************
  // Command outputs
  // ****************************************
  kd_pkg::view_t view_q, view_d;
  logic zcap_d, zclr_d, pclr_d, fnext_d, amp_d, lclr_d, dhold_d, fhold_d;

  // Unlisted chords fire nothing; pulses last one cycle
  always_comb begin
    view_d = view_q;
    zcap_d = fire && chord == `KD_CH_ZERO; // RULE2
    zclr_d = fire && chord == `KD_CH_ZERO_RESET; // RULE5
    pclr_d = fire && chord == `KD_CH_MODE_RESET; // RULE7
    fnext_d = fire && chord == `KD_CH_MODE_ZERO && multi_s2_q; // RULE8
    amp_d = fire && chord == `KD_CH_MODE_LIMITS; // RULE9
    lclr_d = fire && chord == `KD_CH_LIMITS_RESET; // RULE10
    dhold_d = state_q == kd_pkg::ST_DONE
              && chord == `KD_CH_RESET; // RULE4 RULE12
    fhold_d = qual[4]; // RULE13 RULE14
    if (fire && chord == `KD_CH_MODE) begin
      unique case (view_q) // RULE6
        kd_pkg::VIEW_NORMAL: view_d = kd_pkg::VIEW_MAX;
        kd_pkg::VIEW_MAX: view_d = kd_pkg::VIEW_MIN;
        kd_pkg::VIEW_MIN: view_d = kd_pkg::VIEW_TOTAL_INDICATED_READING;
        kd_pkg::VIEW_TOTAL_INDICATED_READING: view_d = kd_pkg::VIEW_NORMAL;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      view_q <= kd_pkg::VIEW_NORMAL;
      o_zero_capture <= 1'b0;
      o_zero_clear <= 1'b0;
      o_peaks_clear <= 1'b0;
      o_function_next <= 1'b0;
      o_amp_check <= 1'b0;
      o_limits_clear <= 1'b0;
      o_digital_hold <= 1'b0;
      o_freeze_display <= 1'b0;
      o_freeze_analogue <= 1'b0;
      o_ind_up <= 1'b0;
      o_ind_down <= 1'b0;
    end else begin
      view_q <= view_d;
      o_zero_capture <= zcap_d;
      o_zero_clear <= zclr_d;
      o_peaks_clear <= pclr_d;
      o_function_next <= fnext_d;
      o_amp_check <= amp_d;
      o_limits_clear <= lclr_d;
      o_digital_hold <= dhold_d;
      o_freeze_display <= fhold_d;
      o_freeze_analogue <= fhold_d;
      o_ind_up <= view_d == kd_pkg::VIEW_MAX
                  || view_d
                  == kd_pkg::VIEW_TOTAL_INDICATED_READING; // RULE18
      o_ind_down <= view_d == kd_pkg::VIEW_MIN
                    || view_d
                    == kd_pkg::VIEW_TOTAL_INDICATED_READING; // RULE18
    end
  end
  assign o_view = view_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  sequence fire_s(logic [3:0] c);
    state_q == kd_pkg::ST_SETTLE && last_q == chord && chord == c
      && cnt_q == CW'(COMBINE_CYC - 1);
  endsequence

  zero_capture_a: assert property ( // RULE2
    fire_s(`KD_CH_ZERO) |=> o_zero_capture ##1 !o_zero_capture)
    else $error("zero capture missing or too long");
  zero_clear_a: assert property ( // RULE5
    fire_s(`KD_CH_ZERO_RESET) |=> o_zero_clear && !o_zero_capture
    && !o_digital_hold)
    else $error("calibration zero not restored");
  view_step_a: assert property ( // RULE6
    fire_s(`KD_CH_MODE) |=> o_view == 2'($past(o_view) + 2'h1))
    else $error("view did not advance one step");
  peaks_clear_a: assert property ( // RULE7
    fire_s(`KD_CH_MODE_RESET) |=> o_peaks_clear && $stable(o_view))
    else $error("peak clear missing");
  // The gate is judged as it stood when the chord fired
  function_gate_a: assert property ( // RULE8
    fire_s(`KD_CH_MODE_ZERO) |=> o_function_next == $past(multi_s2_q))
    else $error("function step ignored its gate");
  amp_check_a: assert property ( // RULE9
    fire_s(`KD_CH_MODE_LIMITS) |=> o_amp_check)
    else $error("amplifier check not started");
  limits_clear_a: assert property ( // RULE10
    fire_s(`KD_CH_LIMITS_RESET) |=> o_limits_clear)
    else $error("latched limits not cleared");
  hold_follow_a: assert property ( // RULE12
    $fell(chord[`KD_BIT_RESET]) |=> !o_digital_hold)
    else $error("digital hold outlived its input");
  fast_both_a: assert property ( // RULE14
    o_freeze_display == o_freeze_analogue
    && o_freeze_display == $past(qual[4]))
    else $error("fast hold freeze mismatch");
  both_indicators_a: assert property ( // RULE18
    o_view == kd_pkg::VIEW_TOTAL_INDICATED_READING
    |-> o_ind_up && o_ind_down)
    else $error("both indicators not lit for total reading");
  once_only_a: assert property ( // RULE19
    $changed(o_view) |=> $stable(o_view) [*2])
    else $error("view stepped twice for one press");
endmodule : key_and_input_command_decoder
`default_nettype wire

// *** bench/contact_model.sv ***
// Purpose: Rear-panel switch contacts driving the decoder inputs
// Assumes: Bench changes press levels on the falling clock edge
// Notes: An open contact reads high, as the line is pulled up
`default_nettype none
module contact_model (
  input wire logic [4:0] i_press,
  output logic o_mode_n,
  output logic o_zero_n,
  output logic o_limits_n,
  output logic o_reset_n,
  output logic o_fast_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Contacts
  // ****
  // Closed contact pulls low, so no stale level is left when open
  assign o_mode_n = ~i_press[4];
  assign o_zero_n = ~i_press[3];
  assign o_limits_n = ~i_press[2];
  assign o_reset_n = ~i_press[1];
  assign o_fast_n = ~i_press[0];
endmodule : contact_model
`default_nettype wire

// *** bench/test_key_and_input_command_decoder.sv ***
// Purpose: Self-checking bench for the key and input command decoder
// Assumes: Short counts, qualify 8 cycles and settle 4 cycles
// Notes: Fast hold keeps its full 2000 cycle qualify time
`default_nettype none
module test_key_and_input_command_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] key = 4'h0;
  logic [3:0] ext = 4'h0;
  logic fast = 1'b0;
  logic multi = 1'b1;
  wire [4:0] ext_n;
  wire [5:0] pulse;
  wire [1:0] view;
  wire hold, frz_d, frz_a, up, down;
  int bad_count = 0;
  int comparisons = 0;
  // ****
  // Clock and instances
  // ****
  // Free-running 20 MHz clock
  always #25 clk = ~clk;
  contact_model partner (.i_press({ext, fast}), .o_mode_n(ext_n[4]),
    .o_zero_n(ext_n[3]), .o_limits_n(ext_n[2]), .o_reset_n(ext_n[1]),
    .o_fast_n(ext_n[0]));
  key_and_input_command_decoder #(.MIN_PULSE_CYC(8), .COMBINE_CYC(4)) dut (
    .i_clk_sys(clk), .i_resetn(rstn), .i_key_mode(key[3]),
    .i_key_zero(key[2]), .i_key_limits(key[1]), .i_key_reset(key[0]),
    .i_ext_mode_n(ext_n[4]), .i_ext_zero_n(ext_n[3]),
    .i_ext_limits_n(ext_n[2]), .i_ext_reset_n(ext_n[1]),
    .i_ext_fast_hold_n(ext_n[0]), .i_multi_function(multi),
    .o_zero_capture(pulse[5]), .o_zero_clear(pulse[4]),
    .o_peaks_clear(pulse[3]), .o_function_next(pulse[2]),
    .o_amp_check(pulse[1]), .o_limits_clear(pulse[0]),
    .o_digital_hold(hold), .o_freeze_display(frz_d),
    .o_freeze_analogue(frz_a), .o_view(view), .o_ind_up(up),
    .o_ind_down(down));
  // ****
  // Helpers
  // ****
  task automatic chk(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  // Hold a chord, release it, and count each pulse output meanwhile
  task automatic run(input string what, input logic [3:0] ch,
    input logic use_ext, input int len, input logic [5:0] exp);
    int n[6] = '{default: 0};
    @(negedge clk);
    if (use_ext) ext = ch;
    else key = ch;
    for (int c = 0; c < len + 12; c++) begin
      @(negedge clk);
      if (c == len) begin
        ext = 4'h0;
        key = 4'h0;
      end
      for (int i = 0; i < 6; i++) if (pulse[i] === 1'b1) n[i]++;
    end
    for (int i = 0; i < 6; i++) begin
      chk(what, {7'h0, exp[i]}, n[i][7:0]);
    end
    $display("test %s done", what);
  endtask : run
  // ****
  // Scenarios
  // ****
  task automatic test_commands();
    run("zero key", 4'h4, 1'b0, 40, 6'h20);
    run("zero ext", 4'h4, 1'b1, 40, 6'h20);
    run("clear zero", 4'h5, 1'b1, 40, 6'h10);
    run("peaks", 4'h9, 1'b1, 40, 6'h08);
    run("amp check", 4'ha, 1'b1, 40, 6'h02);
    run("limits key", 4'h3, 1'b0, 40, 6'h01);
    run("limits ext", 4'h3, 1'b1, 40, 6'h01);
    run("no chord", 4'h6, 1'b0, 40, 6'h00);
    run("function", 4'hc, 1'b1, 40, 6'h04);
    multi = 1'b0;
    run("single function", 4'hc, 1'b0, 40, 6'h00);
    multi = 1'b1;
  endtask : test_commands
  // Pulses too short to qualify must leave no trace
  task automatic test_short();
    run("short zero", 4'h4, 1'b1, 5, 6'h00);
    run("short reset", 4'h1, 1'b1, 5, 6'h00);
    chk("short hold", 8'h00, {7'h0, hold});
  endtask : test_short
  // View must step exactly once per mode press, from normal
  task automatic test_views();
    logic [1:0] v;
    for (int k = 1; k <= 4; k++) begin
      v = k[1:0];
      run("view step", 4'h8, k[0], 40, 6'h00);
      chk("view", {6'h0, v}, {6'h0, view});
      chk("up", {7'h0, v[0]}, {7'h0, up});
      chk("down", {7'h0, v[1]}, {7'h0, down});
    end
  endtask : test_views
  task automatic test_dhold();
    @(negedge clk);
    ext = 4'h1;
    repeat (30) @(negedge clk);
    chk("hold on", 8'h01, {7'h0, hold});
    repeat (100) @(negedge clk);
    chk("hold kept", 8'h01, {7'h0, hold});
    ext = 4'h0;
    repeat (8) @(negedge clk);
    chk("hold off", 8'h00, {7'h0, hold});
    $display("test digital hold done");
  endtask : test_dhold
  // Digital hold joins the fast hold at once, as a driver may choose
  task automatic test_fast();
    int c = 0;
    @(negedge clk);
    fast = 1'b1;
    ext = 4'h1;
    repeat (1900) @(negedge clk);
    chk("early freeze", 8'h00, {6'h0, frz_d, frz_a});
    chk("hold with fast", 8'h01, {7'h0, hold});
    while (frz_d !== 1'b1 && c < 200) begin
      @(negedge clk);
      c++;
    end
    chk("freeze", 8'h03, {6'h0, frz_d, frz_a});
    if (c >= 200) test_done();
    fast = 1'b0;
    ext = 4'h0;
    repeat (8) @(negedge clk);
    chk("thaw", 8'h00, {6'h0, frz_d, frz_a});
    chk("hold released", 8'h00, {7'h0, hold});
    $display("test fast hold done");
  endtask : test_fast
  // ****
  // Main sequence
  // ****
  // Reset for 8 cycles, then each scenario in turn
  initial begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    test_commands();
    test_short();
    test_views();
    test_dhold();
    test_fast();
    test_done();
  end
endmodule : test_key_and_input_command_decoder
`default_nettype wire
